// >>> hw/rbts_cmd_seq.v
`timescale 1ns/100ps
`include "rbts_defs.vh"
// Functional notes
// - Pointer select to read data accepted while read-byte still runs.
// - While busy, new read-byte and triplet command codes are not acknowledged; pointer select still is.
// - Triplet result held in status once busy falls.
// - Serial clock is input only; never stretched.
// - Busy stays high through whole downstream operation, then clears.
// - Read-byte command code is 96h, first byte after write address.
// - Pointer select is E1h followed by a register-select parameter.
// - Every read byte returns the selected register.
module rbts_cmd_seq (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Serial host pins
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  input  wire       addr_pin,
  // Downstream engine
  output reg        op_start,
  output reg  [1:0] op_kind,
  output reg        op_dir_bit,
  input  wire       op_done,
  input  wire [7:0] op_rdata,
  input  wire [2:0] op_trip,
  // Status view
  output wire       line_busy_flag
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam S_IDLE = 6'h01;
  localparam S_ADDR = 6'h02;
  localparam S_ACK  = 6'h04;
  localparam S_WR   = 6'h08;
  localparam S_RD   = 6'h10;
  localparam S_MACK = 6'h20;
  localparam K_RBYTE = 2'h1;
  localparam K_TRIP  = 2'h2;

  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  wire sda_s;

  reg [5:0] state_r;
  reg [5:0] state_nxt;
  reg [7:0] shift_r;
  reg [3:0] bit_r;
  reg       rw_r;
  reg       ack_r;
  reg       drive_r;
  reg [1:0] byte_r;
  reg [7:0] cmd_r;
  reg [7:0] ptr_r;
  reg       busy_r;
  reg [7:0] data_r;
  reg [2:0] trip_r;
  reg       addr_cap_r;
  reg [1:0] addr_sync_r;

  rbts_i2c_rx u_rx (
    .clk       (clk),
    .rst_n     (rst_n),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det),
    .sda_s     (sda_s)
  );

  // Only SDA is ever driven; no SCL output exists
  assign sda_out        = 1'b0;
  assign sda_oe         = drive_r;
  assign line_busy_flag = busy_r;

  wire [7:0] status_w = {trip_r, 4'h0, busy_r};
  // Selected register returned on every read byte
  wire [7:0] rd_sel_w = (ptr_r == `RBTS_PTR_DATA) ? data_r : status_w;
  wire [7:0] rx_byte  = {shift_r[6:0], sda_s};

  // ----------------------------------------
  // Address strap, synchronised and resampled every clock
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_sync_r <= 2'h0;
      addr_cap_r  <= 1'b0;
    end else begin
      addr_sync_r <= {addr_sync_r[0], addr_pin};
      addr_cap_r  <= addr_sync_r[1];
    end
  end

  // ----------------------------------------
  // Byte framing
  // ----------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE:  state_nxt = S_IDLE;
      S_ADDR:  if (scl_fall && bit_r == 4'h8) state_nxt = S_ACK;
      S_ACK:   if (scl_fall) state_nxt = !ack_r ? S_IDLE : (rw_r ? S_RD : S_WR);
      S_WR:    if (scl_fall && bit_r == 4'h8) state_nxt = S_ACK;
      S_RD:    if (scl_fall && bit_r == 4'h8) state_nxt = S_MACK;
      S_MACK:  if (scl_fall) state_nxt = ack_r ? S_RD : S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
    if (start_det)
      state_nxt = S_ADDR;
    else if (stop_det)
      state_nxt = S_IDLE;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= S_IDLE;
      shift_r    <= 8'h00;
      bit_r      <= 4'h0;
      rw_r       <= 1'b0;
      ack_r      <= 1'b0;
      drive_r    <= 1'b0;
      byte_r     <= 2'h0;
      cmd_r      <= 8'h00;
      ptr_r      <= `RBTS_PTR_STATUS;
      busy_r     <= 1'b0;
      data_r     <= 8'h00;
      trip_r     <= 3'h0;
      op_start   <= 1'b0;
      op_kind    <= 2'h0;
      op_dir_bit <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      op_start <= 1'b0;
      // Busy holds until engine reports completion
      if (op_done && busy_r) begin
        busy_r <= 1'b0;
        if (op_kind == K_RBYTE)
          data_r <= op_rdata;
        if (op_kind == K_TRIP)
          trip_r <= op_trip;
      end
      if (start_det) begin
        bit_r   <= 4'h0;
        byte_r  <= 2'h0;
        drive_r <= 1'b0;
      end else if (stop_det) begin
        drive_r <= 1'b0;
      end else begin
        if (scl_rise && (state_r == S_ADDR || state_r == S_WR)) begin
          shift_r <= rx_byte;
          bit_r   <= bit_r + 4'h1;
        end
        if (scl_rise && state_r == S_MACK)
          ack_r <= ~sda_s;
        if (scl_fall) begin
          case (state_r)
            S_ADDR, S_WR: begin
              if (bit_r == 4'h8) begin
                bit_r <= 4'h0;
                if (state_r == S_ADDR) begin
                  rw_r    <= shift_r[0];
                  ack_r   <= (shift_r[7:1] == {`RBTS_ADDR_BASE, addr_cap_r});
                  drive_r <= (shift_r[7:1] == {`RBTS_ADDR_BASE, addr_cap_r});
                end else begin
                  ack_r   <= 1'b0;
                  drive_r <= 1'b0;
                  byte_r  <= (byte_r == 2'h3) ? byte_r : byte_r + 2'h1;
                  if (byte_r == 2'h0) begin
                    cmd_r <= shift_r;
                    // Read-byte and triplet codes refused while busy; pointer select always taken
                    if (shift_r == `RBTS_CMD_PTR_SELECT) begin
                      ack_r   <= 1'b1;
                      drive_r <= 1'b1;
                    end else if (!busy_r && shift_r == `RBTS_CMD_READ_BYTE) begin
                      ack_r    <= 1'b1;
                      drive_r  <= 1'b1;
                      busy_r   <= 1'b1;
                      op_start <= 1'b1;
                      op_kind  <= K_RBYTE;
                    end else if (!busy_r && shift_r == `RBTS_CMD_TRIPLET) begin
                      ack_r   <= 1'b1;
                      drive_r <= 1'b1;
                    end
                  end else if (byte_r == 2'h1 && cmd_r == `RBTS_CMD_PTR_SELECT &&
                               (shift_r == `RBTS_PTR_DATA || shift_r == `RBTS_PTR_STATUS)) begin
                    // Accepted even mid-operation, kept for later reads
                    ptr_r   <= shift_r;
                    ack_r   <= 1'b1;
                    drive_r <= 1'b1;
                  end else if (byte_r == 2'h1 && cmd_r == `RBTS_CMD_TRIPLET && !busy_r) begin
                    busy_r     <= 1'b1;
                    op_start   <= 1'b1;
                    op_kind    <= K_TRIP;
                    op_dir_bit <= shift_r[7];
                    ack_r      <= 1'b1;
                    drive_r    <= 1'b1;
                  end
                end
              end
            end
            S_ACK: begin
              drive_r <= 1'b0;
              if (ack_r && rw_r) begin
                shift_r <= rd_sel_w;
                drive_r <= ~rd_sel_w[7];
                bit_r   <= 4'h1;
              end
            end
            S_RD: begin
              if (bit_r == 4'h8) begin
                drive_r <= 1'b0;
              end else begin
                drive_r <= ~shift_r[~bit_r[2:0]];
                bit_r   <= bit_r + 4'h1;
              end
            end
            S_MACK: begin
              drive_r <= 1'b0;
              if (ack_r) begin
                shift_r <= rd_sel_w;
                drive_r <= ~rd_sel_w[7];
                bit_r   <= 4'h1;
              end
            end
            default: drive_r <= 1'b0;
          endcase
        end
      end
    end
  end
endmodule // rbts_cmd_seq

// >>> hw/rbts_defs.vh
`ifndef RBTS_DEFS_VH
`define RBTS_DEFS_VH
// ----------------------------------------
// Command codes
// ----------------------------------------
`define RBTS_CMD_READ_BYTE   8'h96
`define RBTS_CMD_PTR_SELECT  8'hE1
`define RBTS_CMD_TRIPLET     8'h78
// ----------------------------------------
// Pointer codes
// ----------------------------------------
`define RBTS_PTR_STATUS      8'hF0
`define RBTS_PTR_DATA        8'hE1
// ----------------------------------------
// Status layout
// ----------------------------------------
`define RBTS_ST_BUSY_BIT     0
`define RBTS_ST_TRIP_LSB     5
`define RBTS_ADDR_BASE       6'h0C
`endif

// >>> hw/rbts_i2c_rx.v
`timescale 1ns/100ps
// ----------------------------------------
// Serial bus edge and condition detector
// ----------------------------------------
module rbts_i2c_rx (
  // Clock and reset
  input  wire clk,
  input  wire rst_n,
  // Pins
  input  wire scl_in,
  input  wire sda_in,
  // Events
  output reg  scl_rise,
  output reg  scl_fall,
  output reg  start_det,
  output reg  stop_det,
  output reg  sda_s
);
  reg [1:0] scl_sync_r;
  reg [1:0] sda_sync_r;
  reg       scl_d_r;
  reg       sda_d_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
      scl_rise   <= 1'b0;
      scl_fall   <= 1'b0;
      start_det  <= 1'b0;
      stop_det   <= 1'b0;
      sda_s      <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      scl_d_r    <= scl_sync_r[1];
      sda_d_r    <= sda_sync_r[1];
      sda_s      <= sda_sync_r[1];
      scl_rise   <= scl_sync_r[1] & ~scl_d_r;
      scl_fall   <= ~scl_sync_r[1] & scl_d_r;
      start_det  <= scl_sync_r[1] & scl_d_r & sda_d_r & ~sda_sync_r[1];
      stop_det   <= scl_sync_r[1] & scl_d_r & ~sda_d_r & sda_sync_r[1];
    end
  end
endmodule // rbts_i2c_rx

// >>> dv/rbts_cmd_seq_monitor.sv
`timescale 1ns/100ps
// ----------
// Port checker
// ----------
module rbts_cmd_seq_monitor (
  // Clock and reset
  input wire       clk,
  input wire       rst_n,
  // Watched ports
  input wire       scl_in,
  input wire       sda_out,
  input wire       sda_oe,
  input wire       op_start,
  input wire [1:0] op_kind,
  input wire       op_done,
  input wire       line_busy_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_no_drive_high: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  chk_busy_set: assert property (op_start |=> line_busy_flag)
    else $error("busy not set");
  chk_busy_hold: assert property (line_busy_flag && !op_done |=> line_busy_flag)
    else $error("busy dropped early");
  chk_busy_clear: assert property (op_done |-> ##[1:2] !line_busy_flag)
    else $error("busy stuck");
  chk_refuse_busy: assert property (op_start |-> !$past(line_busy_flag))
    else $error("start while busy");
  chk_kind_code: assert property (op_start |-> op_kind == 2'h1 || op_kind == 2'h2)
    else $error("bad kind");
  chk_start_slot: assert property (op_start |-> !scl_in)
    else $error("start outside low phase");
  chk_oe_low: assert property (!$stable(sda_oe) |-> !scl_in)
    else $error("sda moved while clock high");
  cover property (op_start && op_kind == 2'h1);
  cover property (op_start && op_kind == 2'h2);
  cover property ($fell(line_busy_flag));
endmodule // rbts_cmd_seq_monitor

bind rbts_cmd_seq rbts_cmd_seq_monitor u_mon (.clk(clk), .rst_n(rst_n), .scl_in(scl_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .op_start(op_start), .op_kind(op_kind),
  .op_done(op_done), .line_busy_flag(line_busy_flag));

// >>> dv/rbts_host_model.sv
`timescale 1ns/100ps
// ----------
// Serial bus host
// ----------
module rbts_host_model (
  // Clock
  input  wire  clk,
  // Bus lines
  input  wire  sda,
  output logic scl,
  output logic sda_lo
);
  logic rx;
  initial begin
    scl = 1'b1;
    sda_lo = 1'b0;
  end
  // Quarter bit of 10 clocks leaves room for the pin synchroniser
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic bit_io(input logic b);
    sda_lo = !b;
    w(10);
    scl = 1'b1;
    w(10);
    rx = sda;
    w(10);
    scl = 1'b0;
    w(10);
  endtask
  task automatic start;
    sda_lo = 1'b0;
    w(10);
    scl = 1'b1;
    w(10);
    sda_lo = 1'b1;
    w(10);
    scl = 1'b0;
    w(10);
  endtask
  task automatic stop;
    sda_lo = 1'b1;
    w(10);
    scl = 1'b1;
    w(10);
    sda_lo = 1'b0;
    w(10);
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i]);
    bit_io(1'b1);
    ack = (rx === 1'b0);
  endtask
  task automatic rd(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1);
      d[i] = rx;
    end
    bit_io(last);
  endtask
endmodule // rbts_host_model

// >>> dv/read_byte_triplet_sequencing_test.sv
`timescale 1ns/100ps
`include "rbts_defs.vh"
module read_byte_triplet_sequencing_test;
  logic clk = 1'b0, rst_n = 1'b0, op_done = 1'b0;
  logic [7:0] rdv = 8'h3C;
  logic [2:0] tripv = 3'h0;
  int eng_cnt = 0, num_errors = 0, tests_run = 0;
  wire scl, host_lo, sda_out, sda_oe, op_start, op_dir_bit, line_busy_flag;
  wire [1:0] op_kind;
  wire sda = !(sda_oe || host_lo);
  // Idle data shows the inverse so an early latch is caught
  wire [7:0] op_rdata = op_done ? rdv : ~rdv;
  wire [2:0] op_trip = op_done ? tripv : ~tripv;
  rbts_cmd_seq DUT (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_pin(1'b0), .op_start(op_start), .op_kind(op_kind), .op_dir_bit(op_dir_bit),
    .op_done(op_done), .op_rdata(op_rdata), .op_trip(op_trip), .line_busy_flag(line_busy_flag));
  rbts_host_model HOST (.clk(clk), .sda(sda), .scl(scl), .sda_lo(host_lo));
  initial forever #2.5 clk = ~clk;
  // ----------
  // Downstream engine, long enough to span a full command
  // ----------
  always @(negedge clk) begin
    op_done = 1'b0;
    if (op_start === 1'b1) eng_cnt = 3000;
    else if (eng_cnt > 0) begin
      eng_cnt = eng_cnt - 1;
      op_done = (eng_cnt == 0);
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] p, input logic np, output logic ack);
    logic a;
    HOST.start();
    HOST.wr({`RBTS_ADDR_BASE, 2'h0}, a);
    HOST.wr(c, ack);
    if (ack && np) HOST.wr(p, a);
    HOST.stop();
  endtask
  task automatic rd2(output logic [7:0] d0, output logic [7:0] d1);
    logic a;
    HOST.start();
    HOST.wr({`RBTS_ADDR_BASE, 2'h1}, a);
    HOST.rd(1'b0, d0);
    HOST.rd(1'b1, d1);
    HOST.stop();
  endtask
  task automatic t_poll;
    logic a;
    logic [7:0] s0, s1;
    int n;
    cmd(`RBTS_CMD_PTR_SELECT, `RBTS_PTR_STATUS, 1'b1, a);
    check({7'h0, a}, 8'h01);
    cmd(`RBTS_CMD_READ_BYTE, 8'h00, 1'b0, a);
    check({7'h0, a}, 8'h01);
    rd2(s0, s1);
    check({7'h0, s0[0]}, 8'h01);
    n = 0;
    while (s1[0] !== 1'b0 && n < 20) begin
      rd2(s0, s1);
      n++;
    end
    check({7'h0, s1[0]}, 8'h00);
    cmd(`RBTS_CMD_PTR_SELECT, `RBTS_PTR_DATA, 1'b1, a);
    rd2(s0, s1);
    check(s0, 8'h3C);
    check(s1, 8'h3C);
    $display("test poll done");
  endtask
  task automatic t_early;
    logic a;
    logic [7:0] s0, s1;
    rdv = 8'hA5;
    // Pointer away from read data first, so the early select really matters
    cmd(`RBTS_CMD_PTR_SELECT, `RBTS_PTR_STATUS, 1'b1, a);
    cmd(`RBTS_CMD_READ_BYTE, 8'h00, 1'b0, a);
    cmd(`RBTS_CMD_PTR_SELECT, `RBTS_PTR_DATA, 1'b1, a);
    check({7'h0, a}, 8'h01);
    check({7'h0, line_busy_flag}, 8'h01);
    HOST.w(3200);
    rd2(s0, s1);
    check(s0, 8'hA5);
    $display("test early pointer done");
  endtask
  task automatic t_refuse;
    logic a;
    logic [7:0] s0, s1;
    rdv = 8'h5A;
    cmd(`RBTS_CMD_READ_BYTE, 8'h00, 1'b0, a);
    check({7'h0, a}, 8'h01);
    cmd(`RBTS_CMD_READ_BYTE, 8'h00, 1'b0, a);
    check({7'h0, a}, 8'h00);
    cmd(`RBTS_CMD_TRIPLET, 8'h80, 1'b1, a);
    check({7'h0, a}, 8'h00);
    HOST.w(3200);
    cmd(`RBTS_CMD_PTR_SELECT, `RBTS_PTR_DATA, 1'b1, a);
    check({7'h0, a}, 8'h01);
    rd2(s0, s1);
    check(s0, 8'h5A);
    $display("test busy refusal done");
  endtask
  task automatic t_trip;
    logic a;
    logic [7:0] s0, s1;
    tripv = 3'h5;
    cmd(`RBTS_CMD_PTR_SELECT, `RBTS_PTR_STATUS, 1'b1, a);
    cmd(`RBTS_CMD_TRIPLET, 8'h80, 1'b1, a);
    check({7'h0, a}, 8'h01);
    check({7'h0, op_dir_bit}, 8'h01);
    HOST.w(3200);
    rd2(s0, s1);
    check(s0, 8'hA0);
    check(s1, 8'hA0);
    $display("test triplet done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_poll();
    t_early();
    t_refuse();
    t_trip();
    report_and_stop();
  end
  initial begin
    #400000;
    num_errors++;
    report_and_stop();
  end
endmodule // read_byte_triplet_sequencing_test
